// ### inc/iom_pkg.sv
package iom_pkg;

   // ==========================================================
   // sizes
   localparam int IOM_NPIN = 21;
   localparam int IOM_NID = 7;
   localparam int IOM_NSLOT = 4;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] IOM_OFS_MASK0 = 8'h00;
   localparam logic [7:0] IOM_OFS_MASK1 = 8'h04;
   localparam logic [7:0] IOM_OFS_MASK2 = 8'h08;
   localparam logic [7:0] IOM_OFS_EDGE = 8'h0C;
   localparam logic [7:0] IOM_OFS_FLAG0 = 8'h10;
   localparam logic [7:0] IOM_OFS_FLAG1 = 8'h14;
   localparam logic [7:0] IOM_OFS_FLAG2 = 8'h18;
   localparam logic [7:0] IOM_OFS_GROUP = 8'h1C;
   localparam logic [7:0] IOM_OFS_LOC = 8'h20;
   localparam logic [7:0] IOM_OFS_ANALOG = 8'h24;
   localparam logic [7:0] IOM_OFS_FSEL0 = 8'h28;
   localparam logic [7:0] IOM_OFS_FSEL1 = 8'h2C;
   localparam logic [7:0] IOM_OFS_FSEL2 = 8'h30;
   localparam logic [7:0] IOM_OFS_PRIO = 8'h34;

   // ==========================================================
   // reset values and field positions
   localparam logic [7:0] IOM_RST_REG = 8'h00;
   localparam int IOM_LOC_U0 = 0;
   localparam int IOM_LOC_U1 = 1;
   localparam int IOM_LOC_T4 = 4;
   localparam int IOM_LOC_T3 = 5;
   localparam int IOM_LOC_T1 = 6;
   localparam int IOM_PRI_P0_LSB = 0;
   localparam int IOM_PRI_U0_T1 = 2;
   localparam int IOM_PRI_T1_T4 = 3;
   localparam int IOM_PRI_U1_T3 = 4;
   localparam int IOM_PRI_U0_U1 = 5;
   localparam int IOM_PIN_DD = 17;
   localparam int IOM_PIN_DC = 18;
   localparam int IOM_PIN_XQ2 = 19;
   localparam int IOM_PIN_XQ1 = 20;

   // ==========================================================
   // peripheral ids and pin maps (slot order = ascending pin, but descending for timer 1 pairs at location 1)
   localparam logic [2:0] IOM_U0 = 3'h0;
   localparam logic [2:0] IOM_U1 = 3'h1;
   localparam logic [2:0] IOM_T1LO = 3'h2;
   localparam logic [2:0] IOM_T1HI = 3'h3;
   localparam logic [2:0] IOM_T1C4 = 3'h4;
   localparam logic [2:0] IOM_T3 = 3'h5;
   localparam logic [2:0] IOM_T4 = 3'h6;
   localparam logic [4:0] IOM_NONE = 5'h1F;
   localparam logic [4:0] IOM_MAP [IOM_NID][2][IOM_NSLOT] = '{
      '{'{5'h02, 5'h03, 5'h04, 5'h05}, '{5'h0A, 5'h0B, 5'h0C, 5'h0D}},
      '{'{5'h02, 5'h03, 5'h04, 5'h05}, '{5'h0C, 5'h0D, 5'h0E, 5'h0F}},
      '{'{5'h02, 5'h03, 5'h1F, 5'h1F}, '{5'h0A, 5'h09, 5'h1F, 5'h1F}},
      '{'{5'h04, 5'h05, 5'h1F, 5'h1F}, '{5'h08, 5'h07, 5'h1F, 5'h1F}},
      '{'{5'h06, 5'h1F, 5'h1F, 5'h1F}, '{5'h06, 5'h1F, 5'h1F, 5'h1F}},
      '{'{5'h0B, 5'h0C, 5'h1F, 5'h1F}, '{5'h0E, 5'h0F, 5'h1F, 5'h1F}},
      '{'{5'h08, 5'h09, 5'h1F, 5'h1F}, '{5'h10, 5'h13, 5'h1F, 5'h1F}}};
   // slots given up by a usart: flow pins in uart mode with flow control off, ssn as spi master
   localparam logic [3:0] IOM_FLOW_SLOTS [2][2] = '{'{4'hC, 4'h3}, '{4'h3, 4'h3}};
   localparam logic [3:0] IOM_SSN_SLOTS [2][2] = '{'{4'h4, 4'h1}, '{4'h1, 4'h1}};

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [3:0] dout;
      logic [3:0] doe;
      logic uart_mode;
      logic flow_en;
      logic spi_master;
   } iom_usart_t;

   typedef struct packed {
      logic [4:0] dout;
      logic [4:0] doe;
   } iom_timer_t;

endpackage

// ### hw/iom_io_irq_pin_mux.sv
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
module iom_io_irq_pin_mux (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pins
   input wire logic [iom_pkg::IOM_NPIN-1:0] pin_in_i,
   output logic [iom_pkg::IOM_NPIN-1:0] pin_out_o,
   output logic [iom_pkg::IOM_NPIN-1:0] pin_oe_n_o,
   // general-purpose port logic
   input wire logic [iom_pkg::IOM_NPIN-1:0] gpio_dout_i,
   input wire logic [iom_pkg::IOM_NPIN-1:0] gpio_dir_i,
   // peripherals
   input wire iom_pkg::iom_usart_t usart0_i,
   input wire iom_pkg::iom_usart_t usart1_i,
   input wire iom_pkg::iom_timer_t timer1_i,
   input wire iom_pkg::iom_timer_t timer3_i,
   input wire iom_pkg::iom_timer_t timer4_i,
   output logic [3:0] usart0_in_o,
   output logic [3:0] usart1_in_o,
   output logic [4:0] timer1_in_o,
   output logic [1:0] timer3_in_o,
   output logic [1:0] timer4_in_o,
   // debug, clock and analog control
   input wire logic debug_mode_i,
   input wire logic [1:0] debug_dout_i,
   input wire logic [1:0] debug_doe_i,
   input wire logic slow_osc_source_select_i,
   output logic debug_pull_dis_o,
   output logic crystal_oscillator_analog_o,
   output logic [7:0] adc_in_en_o,
   // interrupt and dma
   output logic [2:0] cpu_port_irq_o,
   output logic port0_dma_trigger_o,
   output logic port1_dma_trigger_o
);
   import iom_pkg::*;

   // ==========================================================
   // registers
   logic [IOM_NPIN-1:0] pin_irq_mask_r;
   logic [IOM_NPIN-1:0] pin_irq_flags_r;
   logic [IOM_NPIN-1:0] pin_function_select_r;
   logic [2:0] edge_select_control_r;
   logic [2:0] group_irq_enable_r;
   logic [7:0] peripheral_location_control_r;
   logic [7:0] analog_pin_enable_r;
   logic [5:0] prio_r;
   logic [IOM_NPIN-1:0] s1_r;
   logic [IOM_NPIN-1:0] s2_r;
   logic [IOM_NPIN-1:0] s3_r;
   logic [IOM_NPIN-1:0] evt;
   logic [IOM_NPIN-1:0] flag_clr;
   logic [IOM_NPIN-1:0] mux_out;
   logic [IOM_NPIN-1:0] mux_oe;
   logic [IOM_NPIN-1:0] claim [IOM_NID];
   logic [IOM_NPIN-1:0] pval [IOM_NID];
   logic [IOM_NPIN-1:0] poe [IOM_NID];
   logic [3:0] sdo [IOM_NID];
   logic [3:0] sdoe [IOM_NID];
   logic [3:0] sin [IOM_NID];
   logic [IOM_NID-1:0] loc;
   logic wr_en;
   logic [31:0] rd_data;

   // ==========================================================
   // wishbone access
   assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
         wb_dat_o <= rd_data;
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      case ({wb_adr_i[7:2], 2'b00})
         IOM_OFS_MASK0: rd_data[7:0] = pin_irq_mask_r[7:0];
         IOM_OFS_MASK1: rd_data[7:0] = pin_irq_mask_r[15:8];
         IOM_OFS_MASK2: rd_data[4:0] = pin_irq_mask_r[20:16];
         IOM_OFS_EDGE: rd_data[2:0] = edge_select_control_r;
         IOM_OFS_FLAG0: rd_data[7:0] = pin_irq_flags_r[7:0];
         IOM_OFS_FLAG1: rd_data[7:0] = pin_irq_flags_r[15:8];
         IOM_OFS_FLAG2: rd_data[4:0] = pin_irq_flags_r[20:16];
         IOM_OFS_GROUP: rd_data[2:0] = group_irq_enable_r;
         IOM_OFS_LOC: rd_data[7:0] = peripheral_location_control_r;
         IOM_OFS_ANALOG: rd_data[7:0] = analog_pin_enable_r;
         IOM_OFS_FSEL0: rd_data[7:0] = pin_function_select_r[7:0];
         IOM_OFS_FSEL1: rd_data[7:0] = pin_function_select_r[15:8];
         IOM_OFS_FSEL2: rd_data[4:0] = pin_function_select_r[20:16];
         IOM_OFS_PRIO: rd_data[5:0] = prio_r;
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_irq_mask_r <= '0;
         pin_function_select_r <= '0;
         edge_select_control_r <= IOM_RST_REG[2:0];
         group_irq_enable_r <= IOM_RST_REG[2:0];
         peripheral_location_control_r <= IOM_RST_REG;
         analog_pin_enable_r <= IOM_RST_REG;
         prio_r <= IOM_RST_REG[5:0];
      end else if (wr_en) begin
         case ({wb_adr_i[7:2], 2'b00})
            IOM_OFS_MASK0: pin_irq_mask_r[7:0] <= wb_dat_i[7:0];
            IOM_OFS_MASK1: pin_irq_mask_r[15:8] <= wb_dat_i[7:0];
            IOM_OFS_MASK2: pin_irq_mask_r[20:16] <= wb_dat_i[4:0];
            IOM_OFS_EDGE: edge_select_control_r <= wb_dat_i[2:0];
            IOM_OFS_GROUP: group_irq_enable_r <= wb_dat_i[2:0];
            IOM_OFS_LOC: peripheral_location_control_r <= wb_dat_i[7:0];
            IOM_OFS_ANALOG: analog_pin_enable_r <= wb_dat_i[7:0];
            IOM_OFS_FSEL0: pin_function_select_r[7:0] <= wb_dat_i[7:0];
            IOM_OFS_FSEL1: pin_function_select_r[15:8] <= wb_dat_i[7:0];
            IOM_OFS_FSEL2: pin_function_select_r[20:16] <= wb_dat_i[4:0];
            IOM_OFS_PRIO: prio_r <= wb_dat_i[5:0];
            default: prio_r <= prio_r;
         endcase
      end
   end

   // ==========================================================
   // pin synchronisers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin_in_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // ==========================================================
   // per-pin edge detect and flag clear decode
   for (genvar i = 0; i < IOM_NPIN; i++) begin : g_evt
      localparam int P = (i < 8) ? 0 : ((i < 16) ? 1 : 2);
      localparam int B = i - 8 * P;
      localparam logic [7:0] FOFS = (P == 0) ? IOM_OFS_FLAG0 : ((P == 1) ? IOM_OFS_FLAG1 : IOM_OFS_FLAG2);
      // edge seen regardless of pin function or direction
      assign evt[i] = edge_select_control_r[P] ? (s3_r[i] & ~s2_r[i]) : (s2_r[i] & ~s3_r[i]);
      assign flag_clr[i] = wr_en & ({wb_adr_i[7:2], 2'b00} == FOFS) & ~wb_dat_i[B];
   end

   // ==========================================================
   // interrupt flags, set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_irq_flags_r <= '0;
      end else begin
         pin_irq_flags_r <= evt | (pin_irq_flags_r & ~flag_clr);
      end
   end

   // ==========================================================
   // port requests and dma triggers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_port_irq_o <= 3'h0;
         port0_dma_trigger_o <= 1'b0;
         port1_dma_trigger_o <= 1'b0;
      end else begin
         cpu_port_irq_o[0] <= group_irq_enable_r[0] & |(pin_irq_flags_r[7:0] & pin_irq_mask_r[7:0]);
         cpu_port_irq_o[1] <= group_irq_enable_r[1] & |(pin_irq_flags_r[15:8] & pin_irq_mask_r[15:8]);
         cpu_port_irq_o[2] <= group_irq_enable_r[2] & |(pin_irq_flags_r[20:16] & pin_irq_mask_r[20:16]);
         port0_dma_trigger_o <= |evt[7:0];
         port1_dma_trigger_o <= |evt[15:8];
      end
   end

   // ==========================================================
   // peripheral slots, locations and claims
   assign loc[IOM_U0] = peripheral_location_control_r[IOM_LOC_U0];
   assign loc[IOM_U1] = peripheral_location_control_r[IOM_LOC_U1];
   assign loc[IOM_T1LO] = peripheral_location_control_r[IOM_LOC_T1];
   assign loc[IOM_T1HI] = peripheral_location_control_r[IOM_LOC_T1];
   assign loc[IOM_T1C4] = peripheral_location_control_r[IOM_LOC_T1];
   assign loc[IOM_T3] = peripheral_location_control_r[IOM_LOC_T3];
   assign loc[IOM_T4] = peripheral_location_control_r[IOM_LOC_T4];

   always_comb begin
      sdo[IOM_U0] = usart0_i.dout;
      sdoe[IOM_U0] = usart0_i.doe;
      sdo[IOM_U1] = usart1_i.dout;
      sdoe[IOM_U1] = usart1_i.doe;
      sdo[IOM_T1LO] = {2'b00, timer1_i.dout[1:0]};
      sdoe[IOM_T1LO] = {2'b00, timer1_i.doe[1:0]};
      sdo[IOM_T1HI] = {2'b00, timer1_i.dout[3:2]};
      sdoe[IOM_T1HI] = {2'b00, timer1_i.doe[3:2]};
      sdo[IOM_T1C4] = {3'b000, timer1_i.dout[4]};
      sdoe[IOM_T1C4] = {3'b000, timer1_i.doe[4]};
      sdo[IOM_T3] = {2'b00, timer3_i.dout[1:0]};
      sdoe[IOM_T3] = {2'b00, timer3_i.doe[1:0]};
      sdo[IOM_T4] = {2'b00, timer4_i.dout[1:0]};
      sdoe[IOM_T4] = {2'b00, timer4_i.doe[1:0]};
   end

   function automatic logic [3:0] released(input iom_usart_t u, input int id, input logic l);
      logic [3:0] r;
      r = 4'h0;
      if (u.uart_mode && !u.flow_en) begin
         r = IOM_FLOW_SLOTS[id][l];
      end else if (!u.uart_mode && u.spi_master) begin
         r = IOM_SSN_SLOTS[id][l];
      end
      return r;
   endfunction

   always_comb begin
      logic [4:0] pn;
      logic [3:0] rel;
      pn = IOM_NONE;
      rel = 4'h0;
      for (int id = 0; id < IOM_NID; id++) begin
         claim[id] = '0;
         pval[id] = '0;
         poe[id] = '0;
         sin[id] = 4'h0;
         rel = (id == int'(IOM_U0)) ? released(usart0_i, 0, loc[id]) :
               (id == int'(IOM_U1)) ? released(usart1_i, 1, loc[id]) : 4'h0;
         for (int s = 0; s < IOM_NSLOT; s++) begin
            pn = IOM_MAP[id][loc[id]][s];
            if (pn != IOM_NONE) begin
               claim[id][pn] = ~rel[s];
               pval[id][pn] = sdo[id][s];
               poe[id][pn] = sdoe[id][s];
               sin[id][s] = s2_r[pn];
            end
         end
      end
   end

   // ==========================================================
   // priority between peripherals sharing a pin
   function automatic logic [2:0] p0_rank(input logic [2:0] id, input logic [1:0] f);
      logic [2:0] r;
      r = 3'h7;
      if (id <= IOM_T1C4) begin
         case (f)
            2'b00: r = (id == IOM_U0) ? 3'h0 : ((id == IOM_U1) ? 3'h1 : 3'h2);
            2'b01: r = (id == IOM_U1) ? 3'h0 : ((id == IOM_U0) ? 3'h1 : 3'h2);
            2'b10: r = (id == IOM_T1LO) ? 3'h0 : ((id == IOM_U1) ? 3'h1 : ((id == IOM_U0) ? 3'h2 : 3'h3));
            default: r = (id == IOM_T1HI) ? 3'h0 : ((id == IOM_U0) ? 3'h1 : ((id == IOM_U1) ? 3'h2 : 3'h3));
         endcase
      end
      return r;
   endfunction

   function automatic logic [2:0] p1_class(input logic [2:0] id);
      logic [2:0] c;
      c = id;
      if (id == IOM_T1HI || id == IOM_T1C4) begin
         c = IOM_T1LO;
      end
      return c;
   endfunction

   function automatic logic beats(input logic [2:0] q, input logic [2:0] p, input int pin, input logic [5:0] pr);
      logic [2:0] cq;
      logic [2:0] cp;
      logic [5:0] pair;
      logic lo_wins;
      cq = p1_class(q);
      cp = p1_class(p);
      pair = (cq < cp) ? {cq, cp} : {cp, cq};
      case (pair)
         {IOM_U0, IOM_U1}: lo_wins = ~pr[IOM_PRI_U0_U1];
         {IOM_U0, IOM_T1LO}: lo_wins = ~pr[IOM_PRI_U0_T1];
         {IOM_U1, IOM_T3}: lo_wins = ~pr[IOM_PRI_U1_T3];
         {IOM_T1LO, IOM_T4}: lo_wins = ~pr[IOM_PRI_T1_T4];
         {IOM_U0, IOM_T3}: lo_wins = ~(pr[IOM_PRI_U0_U1] & pr[IOM_PRI_U1_T3]);
         default: lo_wins = 1'b1;
      endcase
      if (pin < 8) begin
         beats = p0_rank(q, pr[IOM_PRI_P0_LSB +: 2]) < p0_rank(p, pr[IOM_PRI_P0_LSB +: 2]);
      end else begin
         beats = (cq < cp) ? lo_wins : ((cq > cp) ? ~lo_wins : 1'b0);
      end
   endfunction

   for (genvar i = 0; i < IOM_NPIN; i++) begin : g_mux
      always_comb begin
         logic beaten;
         logic [IOM_NID-1:0] win;
         beaten = 1'b0;
         win = '0;
         for (int p = 0; p < IOM_NID; p++) begin
            beaten = 1'b0;
            for (int q = 0; q < IOM_NID; q++) begin
               if (claim[q][i] && beats(q[2:0], p[2:0], i, prio_r)) begin
                  beaten = 1'b1;
               end
            end
            win[p] = claim[p][i] & ~beaten;
         end
         mux_out[i] = 1'b0;
         mux_oe[i] = 1'b0;
         for (int p = 0; p < IOM_NID; p++) begin
            mux_out[i] = mux_out[i] | (win[p] & pval[p][i]);
            mux_oe[i] = mux_oe[i] | (win[p] & poe[p][i]);
         end
      end

      // pin driver: crystal, debug, analog, peripheral, then gpio
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            pin_out_o[i] <= 1'b0;
            pin_oe_n_o[i] <= 1'b1;
         end else if ((i == IOM_PIN_XQ1 || i == IOM_PIN_XQ2) && !slow_osc_source_select_i) begin
            pin_out_o[i] <= 1'b0;
            pin_oe_n_o[i] <= 1'b1;
         end else if ((i == IOM_PIN_DD || i == IOM_PIN_DC) && debug_mode_i) begin
            pin_out_o[i] <= debug_dout_i[(i == IOM_PIN_DC) ? 1 : 0];
            pin_oe_n_o[i] <= ~debug_doe_i[(i == IOM_PIN_DC) ? 1 : 0];
         end else if (i < 8 && analog_pin_enable_r[i % 8]) begin
            pin_out_o[i] <= 1'b0;
            pin_oe_n_o[i] <= 1'b1;
         end else if (pin_function_select_r[i]) begin
            pin_out_o[i] <= mux_out[i];
            pin_oe_n_o[i] <= ~mux_oe[i];
         end else begin
            pin_out_o[i] <= gpio_dout_i[i];
            pin_oe_n_o[i] <= ~gpio_dir_i[i];
         end
      end
   end

   // ==========================================================
   // peripheral inputs and analog controls
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         usart0_in_o <= 4'h0;
         usart1_in_o <= 4'h0;
         timer1_in_o <= 5'h00;
         timer3_in_o <= 2'h0;
         timer4_in_o <= 2'h0;
         adc_in_en_o <= 8'h00;
         debug_pull_dis_o <= 1'b0;
         crystal_oscillator_analog_o <= 1'b1;
      end else begin
         usart0_in_o <= sin[IOM_U0];
         usart1_in_o <= sin[IOM_U1];
         timer1_in_o <= {sin[IOM_T1C4][0], sin[IOM_T1HI][1:0], sin[IOM_T1LO][1:0]};
         timer3_in_o <= sin[IOM_T3][1:0];
         timer4_in_o <= sin[IOM_T4][1:0];
         adc_in_en_o <= analog_pin_enable_r;
         debug_pull_dis_o <= debug_mode_i;
         crystal_oscillator_analog_o <= ~slow_osc_source_select_i;
      end
   end

endmodule

// ### testbench/iom_io_irq_pin_mux_props.sv
`timescale 1ns/100ps
module iom_chk (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // pins and side controls
   input wire logic [20:0] pin_in_i,
   input wire logic [20:0] pin_oe_n_o,
   input wire logic debug_mode_i,
   input wire logic [1:0] debug_doe_i,
   input wire logic slow_osc_source_select_i,
   input wire logic crystal_oscillator_analog_o,
   // events
   input wire logic [2:0] cpu_port_irq_o,
   input wire logic port0_dma_trigger_o,
   input wire logic port1_dma_trigger_o
);
   default clocking dcb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========
   // properties
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus ack missing");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack too long");
   AST_DMA0_CAUSE: assert property (port0_dma_trigger_o |-> $past(pin_in_i[7:0], 3) != $past(pin_in_i[7:0], 4))
      else $error("port0 dma without pin change");
   AST_DMA1_CAUSE: assert property (port1_dma_trigger_o |-> $past(pin_in_i[15:8], 3) != $past(pin_in_i[15:8], 4))
      else $error("port1 dma without pin change");
   AST_IRQ_RISE: assert property ($rose(cpu_port_irq_o[0]) |-> $past(port0_dma_trigger_o) || $past(wb_ack_o, 2))
      else $error("port0 irq rose without cause");
   AST_IRQ_FALL: assert property ($fell(cpu_port_irq_o[0]) |-> $past(wb_ack_o, 2))
      else $error("port0 irq fell without write");
   AST_DBG_DIR: assert property (debug_mode_i |=> pin_oe_n_o[18:17] == ~$past(debug_doe_i))
      else $error("debug pin direction wrong");
   AST_XTAL_OWN: assert property (!slow_osc_source_select_i |=> crystal_oscillator_analog_o && &pin_oe_n_o[20:19])
      else $error("crystal pins not released");
   AST_XTAL_FREE: assert property (slow_osc_source_select_i |=> !crystal_oscillator_analog_o)
      else $error("crystal analog stuck");
   cover property (port0_dma_trigger_o);
   cover property (port1_dma_trigger_o);
   cover property ($rose(cpu_port_irq_o[0]));
endmodule
bind iom_io_irq_pin_mux iom_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pin_in_i, .pin_oe_n_o,
   .debug_mode_i, .debug_doe_i, .slow_osc_source_select_i, .crystal_oscillator_analog_o, .cpu_port_irq_o,
   .port0_dma_trigger_o, .port1_dma_trigger_o);

// ### testbench/iom_pin_model.sv
`timescale 1ns/100ps
module iom_pin_model (
   // far-side levels and design drive
   input wire logic [20:0] ext_lvl_i,
   input wire logic [20:0] dut_out_i,
   input wire logic [20:0] dut_oe_n_i,
   // resolved wire
   output logic [20:0] wire_o
);
   // design drive wins, else the external level
   always_comb begin
      wire_o = (~dut_oe_n_i & dut_out_i) | (dut_oe_n_i & ext_lvl_i);
   end
endmodule

// ### testbench/iom_io_irq_pin_mux_tb.sv
`timescale 1ns/100ps
module iom_io_irq_pin_mux_tb;
   import iom_pkg::*;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00, adc_in_en_o;
   logic [3:0] wb_sel_i = 4'hF, usart0_in_o, usart1_in_o;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [20:0] pin_in_i, pin_out_o, pin_oe_n_o, gpio_dout_i = '0, gpio_dir_i = '0, ext = '0;
   iom_usart_t usart0_i = '0, usart1_i = '0;
   iom_timer_t timer1_i = '0, timer3_i = '0, timer4_i = '0;
   logic [4:0] timer1_in_o;
   logic [1:0] timer3_in_o, timer4_in_o, debug_dout_i = '0, debug_doe_i = '0;
   logic debug_mode_i = 0, slow_osc_source_select_i = 1, debug_pull_dis_o, crystal_oscillator_analog_o;
   logic [2:0] cpu_port_irq_o;
   logic port0_dma_trigger_o, port1_dma_trigger_o;
   int err_count = 0, checks_done = 0, n_dma0 = 0, n_dma1 = 0;
   int rw[6] = '{0, 4, 8, 40, 44, 36};
   // location, priority, pin, source id, slot, usart0 mode (0 spi slave, 1 uart no flow, 2 spi master)
   int tc[14][6] = '{'{0, 0, 2, 0, 0, 0}, '{0, 1, 2, 1, 0, 0}, '{0, 2, 2, 2, 0, 0}, '{0, 3, 4, 2, 2, 0},
      '{0, 3, 2, 0, 0, 0}, '{65, 0, 10, 0, 0, 0}, '{65, 4, 10, 2, 0, 0}, '{65, 12, 9, 6, 1, 0},
      '{65, 4, 9, 2, 1, 0}, '{3, 32, 12, 1, 0, 0}, '{3, 48, 12, 5, 1, 0}, '{3, 16, 12, 0, 2, 0},
      '{0, 0, 4, 1, 2, 1}, '{0, 0, 4, 1, 2, 2}};
   iom_io_irq_pin_mux dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .pin_in_i, .pin_out_o, .pin_oe_n_o, .gpio_dout_i, .gpio_dir_i, .usart0_i, .usart1_i,
      .timer1_i, .timer3_i, .timer4_i, .usart0_in_o, .usart1_in_o, .timer1_in_o, .timer3_in_o, .timer4_in_o,
      .debug_mode_i, .debug_dout_i, .debug_doe_i, .slow_osc_source_select_i, .debug_pull_dis_o,
      .crystal_oscillator_analog_o, .adc_in_en_o, .cpu_port_irq_o, .port0_dma_trigger_o, .port1_dma_trigger_o);
   iom_pin_model far (.ext_lvl_i(ext), .dut_out_i(pin_out_o), .dut_oe_n_i(pin_oe_n_o), .wire_o(pin_in_i));
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      n_dma0 += (port0_dma_trigger_o === 1'b1);
      n_dma1 += (port1_dma_trigger_o === 1'b1);
   end
   // ==========
   // helpers
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      @(posedge clk_i);
   endtask
   function automatic logic src(int id, int s);
      case (id)
         0: return usart0_i.dout[s];
         1: return usart1_i.dout[s];
         2: return timer1_i.dout[s];
         5: return timer3_i.dout[s];
         default: return timer4_i.dout[s];
      endcase
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      tally_and_finish;
   end
   // ==========
   // tests
   initial begin
      logic [31:0] q, r;
      r = $urandom(75);
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      for (int i = 0; i < 14; i++) begin
         bus(8'(i * 4), 0, 8'h00, q);
         chk("reset value", 0, q);
      end
      for (int i = 0; i < 6; i++) begin
         r = $urandom;
         bus(8'(rw[i]), 1, r[7:0], q);
         bus(8'(rw[i]), 0, 8'h00, q);
         chk("read back", (i == 2) ? r[4:0] : r[7:0], q);
      end
      chk("adc enable", r[7:0], adc_in_en_o);
      bus(8'h40, 1, 8'hFF, q);
      bus(8'h40, 0, 8'h00, q);
      chk("unmapped", 0, q);
      for (int i = 0; i < 6; i++) bus(8'(rw[i]), 1, 8'h00, q);
      $display("test registers done");
      bus(8'h1C, 1, 8'h07, q);
      bus(8'h00, 1, 8'h08, q);
      ext[3] <= 1;
      repeat (5) @(posedge clk_i);
      chk("irq p0", 1, cpu_port_irq_o[0]);
      ext[4] <= 1;
      repeat (5) @(posedge clk_i);
      bus(8'h10, 0, 8'h00, q);
      chk("flags p0", 8'h18, q);
      bus(8'h10, 1, 8'hEF, q);
      bus(8'h10, 0, 8'h00, q);
      chk("flags p0", 8'h08, q);
      bus(8'h10, 1, 8'h00, q);
      bus(8'h1C, 1, 8'h06, q);
      ext[4:3] <= 2'b00;
      repeat (5) @(posedge clk_i);
      ext[3] <= 1;
      repeat (5) @(posedge clk_i);
      bus(8'h10, 0, 8'h00, q);
      chk("flags p0", 8'h08, q);
      chk("irq p0", 0, cpu_port_irq_o[0]);
      bus(8'h10, 1, 8'h00, q);
      bus(8'h0C, 1, 8'h01, q);
      ext[5] <= 1;
      ext[3] <= 0;
      repeat (5) @(posedge clk_i);
      bus(8'h10, 0, 8'h00, q);
      chk("flags p0", 8'h08, q);
      chk("dma p0", 4, n_dma0);
      gpio_dir_i[9] <= 1;
      repeat (2) @(posedge clk_i);
      gpio_dout_i[9] <= 1;
      repeat (5) @(posedge clk_i);
      bus(8'h14, 0, 8'h00, q);
      chk("flags p1", 8'h02, q);
      chk("dma p1", 1, n_dma1);
      chk("irq p1", 0, cpu_port_irq_o[1]);
      r = $urandom;
      ext[5:2] <= r[3:0];
      repeat (5) @(posedge clk_i);
      chk("usart0 in", r[3:0], usart0_in_o);
      chk("usart1 in", r[3:0], usart1_in_o);
      chk("timer1 in", r[3:0], timer1_in_o);
      chk("timer3 in", 0, timer3_in_o);
      chk("timer4 in", 2, timer4_in_o);
      $display("test events done");
      bus(8'h28, 1, 8'hFF, q);
      bus(8'h2C, 1, 8'hFF, q);
      for (int c = 0; c < 14; c++) begin
         bus(8'(tc[c][0]), 1, 8'h00, q);
         bus(8'h20, 1, 8'(tc[c][0]), q);
         bus(8'h34, 1, 8'(tc[c][1]), q);
         for (int k = 0; k < 4; k++) begin
            r = $urandom;
            usart0_i <= {r[3:0], 4'hF, (tc[c][5] == 1), (tc[c][5] == 0), (tc[c][5] == 2)};
            usart1_i <= {r[7:4], 4'hF, 3'b010};
            timer1_i <= {r[12:8], 5'h1F};
            timer3_i <= {r[17:13], 5'h1F};
            timer4_i <= {r[22:18], 5'h1F};
            repeat (3) @(posedge clk_i);
            chk("pin out", src(tc[c][3], tc[c][4]), pin_out_o[tc[c][2]]);
            chk("pin oe_n", 0, pin_oe_n_o[tc[c][2]]);
         end
      end
      $display("test mux done");
      r = $urandom;
      gpio_dir_i <= 21'h1EFFFF;
      gpio_dout_i <= r[20:0];
      bus(8'h28, 1, 8'h00, q);
      repeat (2) @(posedge clk_i);
      chk("gpio out", r[2], pin_out_o[2]);
      bus(8'h24, 1, 8'h04, q);
      bus(8'h28, 1, 8'hFF, q);
      repeat (2) @(posedge clk_i);
      chk("analog oe_n", 1, pin_oe_n_o[2]);
      chk("adc enable", 8'h04, adc_in_en_o);
      r = $urandom;
      debug_mode_i <= 1;
      debug_doe_i <= r[1:0];
      debug_dout_i <= r[3:2];
      slow_osc_source_select_i <= 0;
      repeat (3) @(posedge clk_i);
      chk("debug oe_n", {30'h0, ~r[1:0]}, pin_oe_n_o[18:17]);
      chk("debug out", {30'h0, r[3:2] & r[1:0]}, {30'h0, pin_out_o[18:17] & r[1:0]});
      chk("pull off", 1, debug_pull_dis_o);
      chk("crystal_oscillator oe_n", 3, pin_oe_n_o[20:19]);
      chk("crystal_oscillator analog", 1, crystal_oscillator_analog_o);
      $display("test side pins done");
      tally_and_finish;
   end
endmodule
